/* File: ebi_consts.vh */
/*
 * Constants of the external bus interface: widths, space codes, wait-state
 * thresholds and FIFO sizing.
 * Assumes it is included by the design files by bare name; definitions only.
 */
`ifndef EBI_CONSTS_VH
`define EBI_CONSTS_VH

// ----------------------------------------
// Bus widths
// ----------------------------------------
`define EBI_ADDR_W       23
`define EBI_DATA_W       16
`define EBI_LOW_ADDR_W   16
`define EBI_WS_W         3

// ----------------------------------------
// Space codes of a request
// ----------------------------------------
`define EBI_SP_DATA      2'h0
`define EBI_SP_PROG      2'h1
`define EBI_SP_IO        2'h2

// ----------------------------------------
// Wait states and buffering
// ----------------------------------------
`define EBI_READY_MIN_WS 3'h2
`define EBI_FIFO_DEPTH   8
`define EBI_FIFO_AW      3
// Request word: write flag, space, wait states, address, data
`define EBI_REQ_W        (1 + 2 + `EBI_WS_W + `EBI_ADDR_W + `EBI_DATA_W)

`endif

/* File: ebi_fifo.v */
/*
 * Request FIFO of the external bus interface, flip-flop storage.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`include "ebi_consts.vh"

module ebi_fifo #(
	parameter WIDTH = `EBI_REQ_W,
	parameter DEPTH = `EBI_FIFO_DEPTH,
	parameter AW    = `EBI_FIFO_AW
) (
	// Clock and reset
	input  wire             sys_clk,
	input  wire             rst_n,
	// Fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_r;
	reg [AW-1:0]    rd_ptr_r;
	reg [AW:0]      count_r;
	reg [AW:0]      count_nxt;
	reg             in_ready_r;

	wire push = in_valid && in_ready;
	wire pop  = out_valid && out_ready;

	// Not-full is kept in a flip-flop so the ready seen outside is registered
	assign in_ready  = in_ready_r;
	assign out_valid = (count_r != {(AW+1){1'b0}});
	assign out_data  = mem_r[rd_ptr_r];

	always @* begin
		count_nxt = count_r;
		if (push && !pop) begin
			count_nxt = count_r + 1'b1;
		end else if (pop && !push) begin
			count_nxt = count_r - 1'b1;
		end
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r  <= {(AW+1){1'b0}};
			in_ready_r <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			count_r    <= count_nxt;
			in_ready_r <= (count_nxt != DEPTH[AW:0]);
		end
	end

	// Storage needs no reset; empty slots are never read out as valid
	always @(posedge sys_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end
endmodule // ebi_fifo

/* File: ebi_core.v */
/*
 * External bus interface: runs queued read/write requests on an asynchronous
 * external bus with space selects, strobes, ready, and hold handover.
 * Assumes inputs synchronous to sys_clk; pad logic combines each _o with its
 * _oe_n (low = driven) into a three-state pin.
 */
`timescale 1ns/1ps
`include "ebi_consts.vh"

// Overview of operation
// - One space select low during valid address
// - Space selects float in hold mode
// - Space selects float when output disable low
// - Memory strobe low only for memory access
// - Both strobes float in hold or disable
// - I/O strobe low only for I/O access
// - Ready low extends access one cycle, repeat
// - Ready checked only after two+ wait states
// - Direction high except during writes
// - Direction floats in hold or disable
// - Grant floats address, data and control
// - Grant low in hold; floats when disabled
// - Wait-done low first wait, high last
// - Full address floats in hold mode
// - Data floats unless writing; also floats in reset or request
module ebi_core (
	// Clock and reset
	input  wire                     sys_clk,
	input  wire                     rst_n,
	// Request stream from the core
	input  wire                     req_valid,
	output wire                     req_ready,
	input  wire                     req_write,
	input  wire [1:0]               req_space,
	input  wire [`EBI_WS_W-1:0]     req_wait,
	input  wire [`EBI_ADDR_W-1:0]   req_addr,
	input  wire [`EBI_DATA_W-1:0]   req_wdata,
	// Read answer
	output reg                      rd_valid,
	output reg  [`EBI_DATA_W-1:0]   rd_data,
	// Bus control
	input  wire                     ready,
	input  wire                     bus_request_n,
	input  wire                     output_disable_n,
	output reg                      bus_grant_n_o,
	output reg                      bus_grant_n_oe_n,
	output reg                      wait_state_done_o,
	output reg                      wait_state_done_oe_n,
	// Selects and strobes
	output reg                      data_space_sel_n,
	output reg                      program_space_sel_n,
	output reg                      io_space_sel_n,
	output reg                      sel_oe_n,
	output reg                      mem_strobe_n,
	output reg                      io_strobe_n,
	output reg                      strobe_oe_n,
	output reg                      rw_dir,
	output reg                      rw_dir_oe_n,
	// Address and data
	output reg  [`EBI_ADDR_W-1:0]   ext_addr_o,
	output reg                      ext_addr_oe_n,
	input  wire [`EBI_DATA_W-1:0]   ext_data_i,
	output reg  [`EBI_DATA_W-1:0]   ext_data_o,
	output reg                      ext_data_oe_n
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam ST_IDLE   = 2'h0;
	localparam ST_SETUP  = 2'h1;
	localparam ST_ACCESS = 2'h2;
	localparam ST_HOLD   = 2'h3;

	localparam RQ_W = `EBI_REQ_W;

	reg  [1:0]              state_r;
	reg  [1:0]              state_nxt;
	reg  [`EBI_WS_W-1:0]    ws_left_r;
	reg                     cur_write_r;
	reg  [1:0]              cur_space_r;
	reg  [`EBI_WS_W-1:0]    cur_ws_r;
	reg                     want_ready_r;

	wire                    q_valid;
	wire                    q_ready;
	wire [RQ_W-1:0]         q_data;

	ebi_fifo #(
		.WIDTH (RQ_W),
		.DEPTH (`EBI_FIFO_DEPTH),
		.AW    (`EBI_FIFO_AW)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.in_valid  (req_valid),
		.in_ready  (req_ready),
		.in_data   ({req_write, req_space, req_wait, req_addr, req_wdata}),
		.out_valid (q_valid),
		.out_ready (q_ready),
		.out_data  (q_data)
	);

	wire                   q_write = q_data[RQ_W-1];
	wire [1:0]             q_space = q_data[RQ_W-2:RQ_W-3];
	wire [`EBI_WS_W-1:0]   q_ws    = q_data[RQ_W-4:`EBI_ADDR_W+`EBI_DATA_W];
	wire [`EBI_ADDR_W-1:0] q_addr  = q_data[`EBI_ADDR_W+`EBI_DATA_W-1:`EBI_DATA_W];
	wire [`EBI_DATA_W-1:0] q_wdata = q_data[`EBI_DATA_W-1:0];

	// Requests drain only from idle with no hold pending, so a queued access
	// never starts while the bus is being handed over
	assign q_ready = (state_r == ST_IDLE) && bus_request_n && q_valid;

	// Access completes when wait states are spent and, where checked, ready is high
	wire ws_done  = (ws_left_r == {`EBI_WS_W{1'b0}});
	wire acc_done = ws_done && (!want_ready_r || ready);

	function ebi_is_mem;
		input [1:0] sp;
		begin
			ebi_is_mem = (sp == `EBI_SP_DATA) || (sp == `EBI_SP_PROG);
		end
	endfunction

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (!bus_request_n) begin
					state_nxt = ST_HOLD;
				end else if (q_valid) begin
					state_nxt = ST_SETUP;
				end
			end
			ST_SETUP: begin
				state_nxt = ST_ACCESS;
			end
			ST_ACCESS: begin
				if (acc_done) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_HOLD: begin
				if (bus_request_n) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			state_r      <= ST_IDLE;
			ws_left_r    <= {`EBI_WS_W{1'b0}};
			cur_write_r  <= 1'b0;
			cur_space_r  <= `EBI_SP_DATA;
			cur_ws_r     <= {`EBI_WS_W{1'b0}};
			want_ready_r <= 1'b0;
			ext_addr_o   <= {`EBI_ADDR_W{1'b0}};
			ext_data_o   <= {`EBI_DATA_W{1'b0}};
			rd_valid     <= 1'b0;
			rd_data      <= {`EBI_DATA_W{1'b0}};
		end else begin
			state_r  <= state_nxt;
			rd_valid <= 1'b0;
			if (q_ready) begin
				cur_write_r  <= q_write;
				cur_space_r  <= q_space;
				cur_ws_r     <= q_ws;
				ws_left_r    <= q_ws;
				want_ready_r <= (q_ws >= `EBI_READY_MIN_WS);
				// Program space alone uses the upper seven address bits
				ext_addr_o   <= (q_space == `EBI_SP_PROG) ? q_addr :
				                {{(`EBI_ADDR_W-`EBI_LOW_ADDR_W){1'b0}}, q_addr[`EBI_LOW_ADDR_W-1:0]};
				ext_data_o   <= q_wdata;
			end else if (state_r == ST_ACCESS && !ws_done) begin
				ws_left_r <= ws_left_r - 1'b1;
			end
			if (state_r == ST_ACCESS && acc_done && !cur_write_r) begin
				rd_valid <= 1'b1;
				rd_data  <= ext_data_i;
			end
		end
	end

	// ----------------------------------------
	// Pin drivers, all registered from next state and the bus control inputs
	// ----------------------------------------
	wire                 n_busy  = (state_nxt == ST_SETUP) || (state_nxt == ST_ACCESS);
	wire                 n_acc   = (state_nxt == ST_ACCESS);
	wire                 n_hold  = (state_nxt == ST_HOLD);
	wire [1:0]           n_space = (state_r == ST_IDLE) ? q_space : cur_space_r;
	wire                 n_write = (state_r == ST_IDLE) ? q_write : cur_write_r;
	wire [`EBI_WS_W-1:0] n_ws    = (state_r == ST_IDLE) ? q_ws : cur_ws_r;
	// Remaining wait states as seen in the next cycle
	wire [`EBI_WS_W-1:0] n_left  = (state_r == ST_SETUP) ? ws_left_r :
	                               (ws_done ? ws_left_r : ws_left_r - 1'b1);

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			data_space_sel_n     <= 1'b1;
			program_space_sel_n  <= 1'b1;
			io_space_sel_n       <= 1'b1;
			mem_strobe_n         <= 1'b1;
			io_strobe_n          <= 1'b1;
			rw_dir               <= 1'b1;
			wait_state_done_o    <= 1'b1;
			bus_grant_n_o        <= 1'b1;
			sel_oe_n             <= 1'b1;
			strobe_oe_n          <= 1'b1;
			rw_dir_oe_n          <= 1'b1;
			ext_addr_oe_n        <= 1'b1;
			ext_data_oe_n        <= 1'b1;
			wait_state_done_oe_n <= 1'b1;
			bus_grant_n_oe_n     <= 1'b0;
		end else begin
			// Selects span setup and access, one at a time
			data_space_sel_n    <= !(n_busy && n_space == `EBI_SP_DATA);
			program_space_sel_n <= !(n_busy && n_space == `EBI_SP_PROG);
			io_space_sel_n      <= !(n_busy && n_space == `EBI_SP_IO);
			// Strobes only inside the select window
			mem_strobe_n <= !(n_acc && ebi_is_mem(n_space));
			io_strobe_n  <= !(n_acc && n_space == `EBI_SP_IO);
			rw_dir       <= !(n_busy && n_write);
			wait_state_done_o <= !(n_acc && n_ws >= `EBI_READY_MIN_WS &&
			                       n_left != {`EBI_WS_W{1'b0}} &&
			                       !(n_left == 3'h1 && state_nxt == ST_ACCESS && state_r == ST_ACCESS));
			bus_grant_n_o <= !n_hold;
			// Disable overrides any activity; hold floats the bus
			sel_oe_n      <= !output_disable_n || n_hold;
			strobe_oe_n   <= !output_disable_n || n_hold;
			rw_dir_oe_n   <= !output_disable_n || n_hold;
			ext_addr_oe_n <= !output_disable_n || n_hold;
			ext_data_oe_n <= !output_disable_n || !bus_request_n || !(n_busy && n_write);
			wait_state_done_oe_n <= !output_disable_n;
			bus_grant_n_oe_n     <= !output_disable_n;
		end
	end
endmodule // ebi_core

/* File: ebi_mem_model.sv */
/*
 * Behavioural model of an external asynchronous memory with ready.
 * Assumes strobes combined into one low-active line, pulled up when floating.
 */
`timescale 1ns/1ps
module ebi_mem_model (
	// Clock and stall setting
	input  wire        sys_clk,
	input  wire [2:0]  stall,
	// Bus from the interface
	input  wire        stb_n,
	input  wire        rw,
	input  wire [3:0]  addr,
	input  wire [15:0] wd,
	// Answer
	output wire        ready,
	output wire [15:0] rd_q
);
	logic [15:0] mem [0:15];
	logic [15:0] q_r = 16'h0000;
	logic [2:0]  cnt_r = 3'h0;
	wire         rd = !stb_n && rw;
	// Ready stays low for stall strobe cycles, then high
	assign ready = cnt_r >= stall;
	// Released data toggles every cycle so no stale value looks valid
	assign rd_q = rd ? mem[addr] : q_r;
	always @(posedge sys_clk) begin
		cnt_r <= stb_n ? 3'h0 : (cnt_r == 3'h7 ? cnt_r : cnt_r + 3'h1);
		q_r <= rd ? mem[addr] : ~q_r;
		if (!stb_n && !rw)
			mem[addr] <= wd;
	end
endmodule // ebi_mem_model

/* File: ebi_core_assertions.sv */
/*
 * Pin protocol checker of the external bus interface.
 * Assumes one clock and synchronous active-low reset; bound into ebi_core.
 */
`timescale 1ns/1ps
module ebi_chk (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Hold, disable and wait done
	input wire bus_request_n,
	input wire output_disable_n,
	input wire bus_grant_n_o,
	input wire bus_grant_n_oe_n,
	input wire wait_state_done_o,
	// Bus outputs
	input wire data_space_sel_n,
	input wire program_space_sel_n,
	input wire io_space_sel_n,
	input wire sel_oe_n,
	input wire mem_strobe_n,
	input wire io_strobe_n,
	input wire strobe_oe_n,
	input wire rw_dir,
	input wire rw_dir_oe_n,
	input wire ext_addr_oe_n,
	input wire ext_data_oe_n
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire idle = data_space_sel_n & program_space_sel_n & io_space_sel_n;
	wire flt = sel_oe_n & strobe_oe_n & rw_dir_oe_n & ext_addr_oe_n;
	chk_one_sel: assert property ($onehot0(~{data_space_sel_n, program_space_sel_n, io_space_sel_n}))
		else $error("more than one space select low");
	chk_mem_sel: assert property (!mem_strobe_n |-> !data_space_sel_n || !program_space_sel_n)
		else $error("memory strobe outside memory select");
	chk_io_sel: assert property (!io_strobe_n |-> !io_space_sel_n)
		else $error("io strobe outside io select");
	chk_off_float: assert property (!output_disable_n |=> flt && bus_grant_n_oe_n)
		else $error("outputs driven while disabled");
	chk_hold_float: assert property (!bus_grant_n_o && !bus_grant_n_oe_n |-> flt && ext_data_oe_n)
		else $error("outputs driven in hold");
	chk_grant_idle: assert property ($fell(bus_grant_n_o) |-> $past(idle) && !$past(bus_request_n))
		else $error("grant during access or without request");
	chk_grant_hold: assert property (!bus_grant_n_o && !bus_request_n |=> !bus_grant_n_o)
		else $error("grant dropped while requested");
	chk_grant_drop: assert property (!bus_grant_n_o && bus_request_n |=> bus_grant_n_o)
		else $error("grant kept after release");
	chk_rw_acc: assert property (!rw_dir |-> !idle)
		else $error("write direction outside access");
	chk_data_wr: assert property (!ext_data_oe_n |-> !rw_dir)
		else $error("data driven outside write");
	chk_wsd_acc: assert property (!wait_state_done_o |-> !(mem_strobe_n & io_strobe_n))
		else $error("wait done low outside access");
endmodule // ebi_chk
bind ebi_core ebi_chk u_chk (.*);

/* File: external_bus_interface_test.sv */
/*
 * Self-checking bench of ebi_core with a memory model on the bus.
 * Assumes the design files and the constants header are compiled first.
 */
`timescale 1ns/1ps
`include "ebi_consts.vh"
`define CHK(a, e) begin \
	check_count++; \
	if ((a) !== (e)) begin \
		fails++; \
		$display("unexpected at %0t: got %h exp %h", $time, (a), (e)); \
	end \
end
module external_bus_interface_test;
	logic sys_clk = 0, rst_n = 0, req_valid = 0, req_write = 0, bus_request_n = 1, output_disable_n = 1;
	logic [1:0] req_space = 0;
	logic [2:0] req_wait = 0, stall = 0;
	logic [22:0] req_addr = 0;
	logic [15:0] req_wdata = 0;
	wire ready, req_ready, rd_valid, bus_grant_n_o, bus_grant_n_oe_n, wait_state_done_o, wait_state_done_oe_n;
	wire data_space_sel_n, program_space_sel_n, io_space_sel_n, sel_oe_n, mem_strobe_n, io_strobe_n;
	wire strobe_oe_n, rw_dir, rw_dir_oe_n, ext_addr_oe_n, ext_data_oe_n;
	wire [15:0] rd_data, ext_data_i, ext_data_o;
	wire [22:0] ext_addr_o;
	wire stb_n = (mem_strobe_n & io_strobe_n) | strobe_oe_n;
	int fails = 0, check_count = 0, cyc = 0, took = 0;
	ebi_core dut (.*);
	ebi_mem_model mem (.sys_clk(sys_clk), .stall(stall), .stb_n(stb_n), .rw(rw_dir),
		.addr(ext_addr_o[3:0]), .wd(ext_data_o), .ready(ready), .rd_q(ext_data_i));
	always #2.5 sys_clk = ~sys_clk;
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			print_verdict;
		end
	end
	task step(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Leaves req_valid high so pushes may run back to back
	task push(logic w, logic [1:0] sp, logic [2:0] ws, logic [22:0] a, logic [15:0] d);
		{req_valid, req_write, req_space, req_wait, req_addr, req_wdata} = {1'b1, w, sp, ws, a, d};
		for (int i = 0; i < 20 && req_ready !== 1'b1; i++) step(1);
		took = req_ready === 1'b1;
		step(1);
	endtask
	task access(logic w, logic [1:0] sp, logic [2:0] ws, logic [22:0] a, logic [15:0] d, int len);
		int n, lw;
		n = 0;
		lw = 0;
		push(w, sp, ws, a, d);
		req_valid = 0;
		for (int i = 0; i < 20 && stb_n; i++) step(1);
		`CHK(ext_addr_o, sp == 1 ? a : {7'h00, a[15:0]})
		`CHK({sel_oe_n, strobe_oe_n, rw_dir_oe_n, ext_addr_oe_n, ext_data_oe_n}, {4'h0, !w})
		`CHK({data_space_sel_n, program_space_sel_n, io_space_sel_n}, 3'h7 ^ (3'h4 >> sp))
		`CHK({mem_strobe_n, io_strobe_n}, {sp == 2, sp != 2})
		`CHK(rw_dir, !w)
		while (!stb_n && n < 40) begin
			n++;
			lw += !wait_state_done_o;
			step(1);
		end
		`CHK(n, len)
		`CHK(lw > 0, ws >= 2)
		for (int i = 0; i < 5 && !w && rd_valid !== 1'b1; i++) step(1);
		if (!w)
			`CHK(rd_data, d)
		step(1);
	endtask
	task t_spaces;
		for (int s = 0; s < 3; s++) begin
			access(1, s, 0, 23'h7F0000 | s, 16'hC0DE ^ s, 1);
			access(0, s, 0, 23'h7F0000 | s, 16'hC0DE ^ s, 1);
		end
		$display("test spaces done");
	endtask
	task t_ready;
		stall = 5;
		access(0, 0, 2, 23'h000000, 16'hC0DE, 6);
		access(0, 0, 1, 23'h000000, 16'hC0DE, 2);
		stall = 0;
		access(0, 0, 2, 23'h000000, 16'hC0DE, 3);
		access(0, 0, 3, 23'h000000, 16'hC0DE, 4);
		$display("test ready done");
	endtask
	task t_hold;
		int n;
		n = 0;
		push(0, 0, 3, 23'h000000, 16'h0000);
		req_valid = 0;
		for (int i = 0; i < 20 && stb_n; i++) step(1);
		bus_request_n = 0;
		step(2);
		`CHK({bus_grant_n_o, stb_n}, 2'h2)
		for (int i = 0; i < 10 && bus_grant_n_o !== 1'b0; i++) step(1);
		`CHK({bus_grant_n_o, stb_n}, 2'h1)
		`CHK({sel_oe_n, strobe_oe_n, rw_dir_oe_n, ext_addr_oe_n, ext_data_oe_n}, 5'h1F)
		for (int i = 0; i < 9; i++) begin
			push(0, 1, 0, 23'h000001, 16'h0000);
			n += took;
		end
		req_valid = 0;
		`CHK(n, 8)
		`CHK(program_space_sel_n, 1'b1)
		bus_request_n = 1;
		n = 0;
		for (int i = 0; i < 200; i++) begin
			n += rd_valid === 1'b1;
			step(1);
		end
		`CHK(n, 8)
		$display("test hold done");
	endtask
	task t_off;
		push(1, 2, 3, 23'h000002, 16'h5A5A);
		req_valid = 0;
		for (int i = 0; i < 20 && stb_n; i++) step(1);
		output_disable_n = 0;
		step(2);
		`CHK({sel_oe_n, strobe_oe_n, rw_dir_oe_n, ext_addr_oe_n, bus_grant_n_oe_n, wait_state_done_oe_n}, 6'h3F)
		output_disable_n = 1;
		step(10);
		`CHK({sel_oe_n, strobe_oe_n, rw_dir_oe_n, ext_addr_oe_n}, 4'h0)
		`CHK(bus_grant_n_oe_n, 1'b0)
		$display("test disable done");
	endtask
	initial begin
		step(10);
		`CHK({bus_grant_n_o, bus_grant_n_oe_n, data_space_sel_n, program_space_sel_n, io_space_sel_n}, 5'h17)
		rst_n = 1;
		step(2);
		t_spaces;
		t_ready;
		t_hold;
		t_off;
		print_verdict;
	end
endmodule // external_bus_interface_test
